// ===== rtl/pdc_top.sv
// Register store, calibration control and divider chains of both loops.
// Assumes pin inputs are asynchronous and that cfg comes from logic on clk.
//
// Contract
// (R1) Feedback divider 18 bits, zero invalid.
// (R2) Writing feedback register starts calibration; the code starts none in the two external oscillator modes.
// (R3) Calibration divider replaces feedback divider meanwhile.
// (R4) Polarity bit sets latch level for readback.
// (R5) Select field picks readback register; some reserved.
// (R6) Register twelve readback carries select field.
// (R7) Host ignores upper bits of protect readback.
// (R8) Protect bit blocks writes to lower registers.
// (R9) Protect register stays writable while protected.
// (R10) Readback works regardless of protection.
// (R11) Channel dividers 2..1045; post divider bypassable.
// (R12) Host usually bypasses post divider.
// (R13) Host matches both phase detector frequencies.
// (R14) Loop one reference: prescaler then divider.
// (R15) Dual mode: oscillator, optional input divider, divider.
// (R16) Zero-delay: core, channel divider, loop divider.
// (R17) Loop two reference: optional doubler, divider.
// (R18) Direct path: core, prescaler, feedback divider.
// (R19) Post path or external: post divider first.
// (R20) Single zero-delay: channel divider, no prescaler.
// (R21) Calibration: core, prescaler, calibration divider.
// (R22) Prescaler code zero eight, one-two two.
// (R23) Calibration also issues output synchronisation.
`timescale 1ns/10ps
module pdc_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk_pin,
    input wire logic data_pin,
    input wire logic le_pin,
    input wire logic ref_pin,
    input wire logic osc_pin,
    input wire logic core_osc_pin,
    input wire pdc_pkg::pdc_cfg_t cfg,
    output logic rb_dout,
    output pdc_pkg::pdc_ticks_t ticks,
    output logic sync_pulse,
    output logic cal_busy
);
    import pdc_pkg::*;

    typedef struct packed {
        logic [NREGS-1:0][WORD_W-1:0] regs;
        logic cal_busy;
        logic [CAL_CNT_W-1:0] cal_cnt;
        logic sync_pulse;
        logic [1:0] ref_s;
        logic [1:0] osc_s;
        logic [1:0] core_s;
        logic ref_d;
        logic osc_d;
        logic core_d;
        pdc_ticks_t ticks;
    } pdc_top_state_t;

    pdc_top_state_t st_reg;
    pdc_top_state_t st_next;

    pdc_wr_t wr;
    logic ser_dout;
    logic [WORD_W-1:0] rb_word;
    logic [RB_SEL_W-1:0] rb_sel;
    logic locked;
    logic ext_mode;
    logic zd_loop1;
    logic wr_ok;
    logic ref_tick;
    logic osc_rise;
    logic osc_fall;
    logic core_tick;
    logic pre_out;
    logic r1_out;
    logic oscd_out;
    logic post_out;
    logic core_path;
    logic chan_out;
    logic n1_in;
    logic n1_out;
    logic r2_in;
    logic r2_out;
    logic p2_out;
    logic n2_in;
    logic n2_out;
    logic [PRER_W-1:0] prer_code;
    logic [PRER_RATIO_W-1:0] prer_ratio;
    logic [CH_DIV_W-1:0] chan_ratio;
    logic [PRESC_W:0] p2_ratio;
    logic [FB_DIV_W-1:0] n2_ratio;
    logic [FB_DIV_W-1:0] fb_div;
    logic [FB_DIV_W-1:0] cal_div;

    ////////////////////////////////////////////////////////////////////////
    // Serial control port.
    pdc_serial u_serial (
        .clk(clk),
        .srst(srst),
        .sclk_pin(sclk_pin),
        .data_pin(data_pin),
        .le_pin(le_pin),
        .rb_word(rb_word),
        .rb_pol(st_reg.regs[ADDR_PROT][RB_POL_BIT]),
        .wr(wr),
        .rb_dout(ser_dout)
    );

    // Protection: the protect register itself is always open.
    assign locked = st_reg.regs[ADDR_PROT][PROT_BIT];
    assign wr_ok = wr.valid && (wr.addr == ADDR_PROT || !locked); // R8 R9

    // Readback word; reserved select codes return zeros.
    assign rb_sel = st_reg.regs[ADDR_PROT][RB_SEL_LSB +: RB_SEL_W];
    always_comb
    begin
        rb_word = st_reg.regs[rb_sel]; // R5
        unique case (rb_sel)
            5'h09, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17: rb_word = '0;
            ADDR_STATUS_RB: rb_word[RB_SEL_LSB +: RB_SEL_W] = rb_sel; // R6
            default: rb_word = st_reg.regs[rb_sel];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode.
    assign ext_mode = cfg.mode == MODE_EXT || cfg.mode == MODE_EXT_ZD;
    assign zd_loop1 = cfg.mode == MODE_DUAL_ZD || cfg.mode == MODE_EXT_ZD;

    // Edges of the synchronised pins act as ticks; a doubled reference counts both edges.
    assign ref_tick = st_reg.ref_s[1] && !st_reg.ref_d;
    assign osc_rise = st_reg.osc_s[1] && !st_reg.osc_d;
    assign osc_fall = !st_reg.osc_s[1] && st_reg.osc_d;
    assign core_tick = st_reg.core_s[1] && !st_reg.core_d;

    ////////////////////////////////////////////////////////////////////////
    // Loop one reference path.
    assign prer_code = cfg.ref_sel ? st_reg.regs[ADDR_LOOP1_REF][PRER1_LSB +: PRER_W]
                                   : st_reg.regs[ADDR_LOOP1_REF][PRER0_LSB +: PRER_W];
    assign prer_ratio = PRER_RATIO_W'(1) << prer_code;

    pdc_tick_div #(.W(PRER_RATIO_W)) u_prescale (
        .clk(clk), .srst(srst), .tick_in(ref_tick), .ratio(prer_ratio), .tick_out(pre_out) // R14
    );
    pdc_tick_div #(.W(R1_W)) u_loop1_ref (
        .clk(clk), .srst(srst), .tick_in(pre_out),
        .ratio(st_reg.regs[ADDR_LOOP1_REF][R1_LSB +: R1_W]), .tick_out(r1_out) // R14
    );

    ////////////////////////////////////////////////////////////////////////
    // Core path, post divider and output channel.
    pdc_tick_div #(.W(POST_DIV_W)) u_post (
        .clk(clk), .srst(srst), .tick_in(core_tick), .ratio(cfg.post_ratio), .tick_out(post_out)
    );
    // External modes always pass the post divider; otherwise it is bypassable.
    assign core_path = (cfg.post_sel || ext_mode) ? post_out : core_tick; // R11 R19
    assign chan_ratio = cfg.fb_chan_sel ? cfg.chan_b_ratio : cfg.chan_a_ratio; // R16

    pdc_tick_div #(.W(CH_DIV_W)) u_chan (
        .clk(clk), .srst(srst), .tick_in(core_path), .ratio(chan_ratio), .tick_out(chan_out) // R11
    );

    ////////////////////////////////////////////////////////////////////////
    // Loop one feedback path.
    pdc_tick_div #(.W(OSC_DIV_W)) u_osc_div (
        .clk(clk), .srst(srst), .tick_in(osc_rise), .ratio(cfg.osc_div_ratio), .tick_out(oscd_out)
    );
    assign n1_in = zd_loop1 ? chan_out : (cfg.osc_src_div ? oscd_out : osc_rise); // R15 R16

    pdc_tick_div #(.W(N1_W)) u_loop1_fb (
        .clk(clk), .srst(srst), .tick_in(n1_in),
        .ratio(st_reg.regs[ADDR_DIVS][N1_LSB +: N1_W]), .tick_out(n1_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Loop two reference path.
    assign r2_in = st_reg.regs[ADDR_DBL][DBL_BIT] ? (osc_rise || osc_fall) : osc_rise; // R17

    pdc_tick_div #(.W(R2_W)) u_loop2_ref (
        .clk(clk), .srst(srst), .tick_in(r2_in),
        .ratio(st_reg.regs[ADDR_DIVS][R2_LSB +: R2_W]), .tick_out(r2_out) // R17
    );

    ////////////////////////////////////////////////////////////////////////
    // Loop two feedback path; the calibration divider stands in while calibrating.
    assign p2_ratio = pdc_presc_ratio(st_reg.regs[ADDR_FB][PRESC_LSB +: PRESC_W]); // R22
    assign fb_div = st_reg.regs[ADDR_FB][FB_DIV_LSB +: FB_DIV_W];
    assign cal_div = st_reg.regs[ADDR_CAL][FB_DIV_LSB +: FB_DIV_W];
    assign n2_ratio = st_reg.cal_busy ? cal_div : fb_div; // R3 R21

    pdc_tick_div #(.W(PRESC_W + 1)) u_loop2_presc (
        .clk(clk), .srst(srst), .tick_in(core_path), .ratio(p2_ratio), .tick_out(p2_out) // R18
    );
    // Single-loop zero-delay skips the prescaler, except during calibration.
    assign n2_in = (cfg.mode == MODE_SINGLE_ZD && !st_reg.cal_busy) ? chan_out : p2_out; // R20 R21

    pdc_tick_div #(.W(FB_DIV_W)) u_loop2_fb (
        .clk(clk), .srst(srst), .tick_in(n2_in), .ratio(n2_ratio), .tick_out(n2_out) // R1 R18
    );

    ////////////////////////////////////////////////////////////////////////
    // Register store, calibration timer and pin synchronisers.
    always_comb
    begin
        st_next = st_reg;
        st_next.ref_s = {st_reg.ref_s[0], ref_pin};
        st_next.osc_s = {st_reg.osc_s[0], osc_pin};
        st_next.core_s = {st_reg.core_s[0], core_osc_pin};
        st_next.ref_d = st_reg.ref_s[1];
        st_next.osc_d = st_reg.osc_s[1];
        st_next.core_d = st_reg.core_s[1];
        st_next.sync_pulse = 1'b0;
        st_next.ticks = '{pd1_ref: r1_out, pd1_fb: n1_out, pd2_ref: r2_out, pd2_fb: n2_out};
        if (st_reg.cal_busy)
        begin
            if (st_reg.cal_cnt == '0)
                st_next.cal_busy = 1'b0;
            else
                st_next.cal_cnt = st_reg.cal_cnt - CAL_CNT_W'(1);
        end
        if (wr_ok)
        begin
            st_next.regs[wr.addr] = wr.data; // R8 R9
            // A fresh write restarts a calibration already under way.
            if (wr.addr == ADDR_FB && !ext_mode)
            begin
                st_next.cal_busy = 1'b1; // R2
                st_next.cal_cnt = CAL_CNT_W'(CAL_CYCLES - 1);
                st_next.sync_pulse = 1'b1; // R23
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign rb_dout = ser_dout;
    assign ticks = st_reg.ticks;
    assign sync_pulse = st_reg.sync_pulse;
    assign cal_busy = st_reg.cal_busy;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    AST_CAL_START: assert property (@(posedge clk) disable iff (srst) // R2
        (wr.valid && !locked && wr.addr == ADDR_FB && !ext_mode) |=> cal_busy [*8])
        else $error("Feedback write did not start calibration.");

    AST_SYNC_ONCE: assert property (@(posedge clk) disable iff (srst) // R23
        (wr.valid && !locked && wr.addr == ADDR_FB && !ext_mode) |=> sync_pulse ##1 !sync_pulse)
        else $error("Calibration did not issue one synchronisation pulse.");

    AST_CAL_DIV_USED: assert property (@(posedge clk) disable iff (srst) // R3
        cal_busy |-> n2_ratio == st_reg.regs[ADDR_CAL][FB_DIV_LSB +: FB_DIV_W])
        else $error("Calibration divider not used while calibrating.");

    AST_NORMAL_DIV_BACK: assert property (@(posedge clk) disable iff (srst) // R3
        $fell(cal_busy) |-> n2_ratio == st_reg.regs[ADDR_FB][FB_DIV_LSB +: FB_DIV_W])
        else $error("Normal feedback divider not restored after calibration.");

    AST_LOCK_BLOCKS: assert property (@(posedge clk) disable iff (srst) // R8
        (wr.valid && locked && wr.addr != ADDR_PROT) |=> $stable(st_reg.regs))
        else $error("Write accepted while protected.");

    AST_PROT_WRITABLE: assert property (@(posedge clk) disable iff (srst) // R9
        (wr.valid && wr.addr == ADDR_PROT) |=> st_reg.regs[ADDR_PROT] == $past(wr.data))
        else $error("Protect register write was lost.");

    AST_PRESC_ZERO: assert property (@(posedge clk) disable iff (srst) // R22
        (st_reg.regs[ADDR_FB][PRESC_LSB +: PRESC_W] == '0) |-> p2_ratio == PRESC_ZERO_DIV)
        else $error("Prescaler code zero does not divide by eight.");

    AST_RB12_SEL: assert property (@(posedge clk) disable iff (srst) // R6
        (rb_sel == ADDR_STATUS_RB) |-> rb_word[RB_SEL_LSB +: RB_SEL_W] == ADDR_STATUS_RB)
        else $error("Register twelve readback lacks the select field.");

    // External oscillator modes have no calibration to run.
    AST_EXT_NO_CAL: assert property (@(posedge clk) disable iff (srst) // R2
        (wr.valid && wr.addr == ADDR_FB && ext_mode && !cal_busy) |=> !cal_busy)
        else $error("Calibration started with an external oscillator.");

    AST_CAL_ENDS: assert property (@(posedge clk) disable iff (srst) // R3
        (cal_busy && st_reg.cal_cnt == '0 && !wr_ok) |=> !cal_busy)
        else $error("Calibration did not end.");

    AST_RB_RESERVED: assert property (@(posedge clk) disable iff (srst) // R5
        (rb_sel == 5'h09 || rb_sel == 5'h16 || rb_sel == 5'h17) |-> rb_word == '0)
        else $error("Reserved readback code returned data.");

    AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (srst) // R8
        wr_ok |=> st_reg.regs[$past(wr.addr)] == $past(wr.data))
        else $error("Accepted write did not land.");

    AST_SYNC_IN_CAL: assert property (@(posedge clk) disable iff (srst) // R23
        sync_pulse |-> cal_busy)
        else $error("Synchronisation pulse outside calibration.");

endmodule : pdc_top

// ===== rtl/pdc_pkg.sv
// Shared constants and types for the divider-chain and configuration block.
// Assumes a single 20 MHz clock domain and the three-wire serial control port.
package pdc_pkg;

    // Serial word layout: low bits carry the register address.
    localparam int WORD_W = 32;
    localparam int ADDR_W = 5;
    localparam int NREGS = 32;

    // Register addresses.
    localparam logic [ADDR_W-1:0] ADDR_STATUS_RB = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_DBL = 5'h1A;
    localparam logic [ADDR_W-1:0] ADDR_LOOP1_REF = 5'h1B;
    localparam logic [ADDR_W-1:0] ADDR_DIVS = 5'h1C;
    localparam logic [ADDR_W-1:0] ADDR_CAL = 5'h1D;
    localparam logic [ADDR_W-1:0] ADDR_FB = 5'h1E;
    localparam logic [ADDR_W-1:0] ADDR_PROT = 5'h1F;

    // Field positions.
    localparam int FB_DIV_LSB = 5;
    localparam int FB_DIV_W = 18;
    localparam int PRESC_LSB = 24;
    localparam int PRESC_W = 3;
    localparam int RB_POL_BIT = 21;
    localparam int RB_SEL_LSB = 16;
    localparam int RB_SEL_W = 5;
    localparam int PROT_BIT = 5;
    localparam int DBL_BIT = 29;
    localparam int PRER0_LSB = 20;
    localparam int PRER1_LSB = 22;
    localparam int PRER_W = 2;
    localparam int PRER_RATIO_W = 4;
    localparam int R1_LSB = 6;
    localparam int R1_W = 14;
    localparam int R2_LSB = 20;
    localparam int R2_W = 12;
    localparam int N1_LSB = 6;
    localparam int N1_W = 14;
    localparam int CH_DIV_W = 11;
    localparam int POST_DIV_W = 3;
    localparam int OSC_DIV_W = 8;

    // Prescaler code zero selects this ratio.
    localparam logic [PRESC_W:0] PRESC_ZERO_DIV = 4'h8;
    localparam logic [PRESC_W:0] PRESC_LOW_DIV = 4'h2;
    localparam logic [PRESC_W-1:0] PRESC_LOW_MAX = 3'h2;

    // Calibration duration.
    localparam int CLK_PERIOD_NS = 50;
    localparam int CAL_TIME_NS = 100000;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_CNT_W = 12;

    typedef enum logic [2:0] {
        MODE_DUAL,
        MODE_DUAL_ZD,
        MODE_SINGLE,
        MODE_SINGLE_ZD,
        MODE_EXT,
        MODE_EXT_ZD
    } pdc_mode_t;

    // Loose configuration bits held by other registers outside this block.
    typedef struct packed {
        pdc_mode_t mode;
        logic post_sel;
        logic [POST_DIV_W-1:0] post_ratio;
        logic osc_src_div;
        logic [OSC_DIV_W-1:0] osc_div_ratio;
        logic fb_chan_sel;
        logic [CH_DIV_W-1:0] chan_a_ratio;
        logic [CH_DIV_W-1:0] chan_b_ratio;
        logic ref_sel;
    } pdc_cfg_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } pdc_wr_t;

    typedef struct packed {
        logic pd1_ref;
        logic pd1_fb;
        logic pd2_ref;
        logic pd2_fb;
    } pdc_ticks_t;

    // Decodes the second-loop prescaler code into a divide ratio.
    function automatic logic [PRESC_W:0] pdc_presc_ratio(input logic [PRESC_W-1:0] code);
        if (code == '0)
            pdc_presc_ratio = PRESC_ZERO_DIV;
        else if (code <= PRESC_LOW_MAX)
            pdc_presc_ratio = PRESC_LOW_DIV;
        else
            pdc_presc_ratio = {1'b0, code};
    endfunction : pdc_presc_ratio

endpackage : pdc_pkg

// ===== rtl/pdc_tick_div.sv
// Integer divider on a stream of one-cycle ticks.
// Assumes tick_in comes from logic on clk; a ratio of zero stops the output.
`timescale 1ns/10ps
module pdc_tick_div #(
    parameter int W = 18
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic tick_in,
    input wire logic [W-1:0] ratio,
    output logic tick_out
);
    import pdc_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic out;
    } pdc_div_state_t;

    pdc_div_state_t st_reg;
    pdc_div_state_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // Count input ticks; a count past a lowered ratio wraps on the next input tick.
    always_comb
    begin
        st_next = st_reg;
        st_next.out = 1'b0;
        if (tick_in && ratio != '0) // R1
        begin
            if (st_reg.cnt >= ratio - W'(1))
            begin
                st_next.cnt = '0;
                st_next.out = 1'b1;
            end
            else
                st_next.cnt = st_reg.cnt + W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tick_out = st_reg.out;

    AST_DIV_ZERO_SILENT: assert property (@(posedge clk) disable iff (srst) // R1
        (ratio == '0) |=> !tick_out)
        else $error("Divider produced a tick with a zero ratio.");

endmodule : pdc_tick_div

// ===== rtl/pdc_serial.sv
// Three-wire serial control port: shift-in, latch, and readback shift-out.
// Assumes the pins are asynchronous to clk and toggle well below half its rate.
`timescale 1ns/10ps
module pdc_serial (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk_pin,
    input wire logic data_pin,
    input wire logic le_pin,
    input wire logic [pdc_pkg::WORD_W-1:0] rb_word,
    input wire logic rb_pol,
    output pdc_pkg::pdc_wr_t wr,
    output logic rb_dout
);
    import pdc_pkg::*;

    typedef struct packed {
        logic [1:0] sclk_s;
        logic [1:0] data_s;
        logic [1:0] le_s;
        logic sclk_d;
        logic le_d;
        logic load_pend;
        logic [WORD_W-1:0] shift;
        logic [WORD_W-1:0] rb_shift;
        pdc_wr_t wr;
    } pdc_ser_state_t;

    pdc_ser_state_t st_reg;
    pdc_ser_state_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // Only the second stage of each synchroniser is looked at.
    always_comb
    begin
        st_next = st_reg;
        st_next.sclk_s = {st_reg.sclk_s[0], sclk_pin};
        st_next.data_s = {st_reg.data_s[0], data_pin};
        st_next.le_s = {st_reg.le_s[0], le_pin};
        st_next.sclk_d = st_reg.sclk_s[1];
        st_next.le_d = st_reg.le_s[1];
        st_next.wr.valid = 1'b0;
        st_next.load_pend = st_reg.wr.valid;
        if (st_reg.sclk_s[1] && !st_reg.sclk_d)
            st_next.shift = {st_reg.shift[WORD_W-2:0], st_reg.data_s[1]};
        // A rising latch edge completes a write; protection is judged downstream in pdc_top.
        if (st_reg.le_s[1] && !st_reg.le_d)
        begin
            st_next.wr.valid = 1'b1;
            st_next.wr.addr = st_reg.shift[ADDR_W-1:0];
            st_next.wr.data = st_reg.shift;
        end
        // The readback word is taken one cycle after the write lands, so a new select field is seen.
        if (st_reg.load_pend) // R10
            st_next.rb_shift = rb_word;
        else if (!st_reg.sclk_s[1] && st_reg.sclk_d && st_reg.le_s[1] == rb_pol) // R4
            st_next.rb_shift = {st_reg.rb_shift[WORD_W-2:0], 1'b0};
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign wr = st_reg.wr;
    assign rb_dout = st_reg.rb_shift[WORD_W-1];

    AST_RB_LOAD_ANY_LOCK: assert property (@(posedge clk) disable iff (srst) // R10
        st_reg.load_pend |=> st_reg.rb_shift == $past(rb_word))
        else $error("Readback word was not loaded.");

endmodule : pdc_serial

// ===== bench/pdc_host_model.sv
// Host controller model that drives the three-wire serial control port.
// Assumes the device samples these pins on clk; every pin change follows a clk falling edge.
`timescale 1ns/10ps
module pdc_host_model (
    input wire logic clk,
    input wire logic rb_dout,
    output logic sclk_pin,
    output logic data_pin,
    output logic le_pin
);
    import pdc_pkg::*;

    // Each level is held four clocks, above the three that the synchronisers need.
    localparam int HOLD = 4;

    // The serial clock stands still low outside frames.
    initial
    begin
        sclk_pin = 1'b0;
        data_pin = 1'b0;
        le_pin = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask : hold

    // Shifts a whole word MSB first, then latches it with one latch-enable pulse.
    task automatic write_word(input logic [WORD_W-1:0] w);
        for (int i = WORD_W - 1; i >= 0; i--)
        begin
            data_pin = w[i];
            hold(HOLD);
            sclk_pin = 1'b1;
            hold(HOLD);
            sclk_pin = 1'b0;
        end
        // Parking the inverse keeps a stale data level from passing for a driven one.
        data_pin = ~w[0];
        hold(HOLD);
        le_pin = 1'b1;
        hold(HOLD);
        le_pin = 1'b0;
        hold(2 * HOLD);
    endtask : write_word

    // Selects a register through the protect register, then clocks its word out.
    task automatic read_reg(input logic [RB_SEL_W-1:0] sel, input logic pol, input logic prot,
                            output logic [WORD_W-1:0] rd);
        write_word({10'h000, pol, sel, 10'h000, prot, ADDR_PROT});
        // A high latch level relatches the same word, which is harmless.
        le_pin = pol;
        hold(3 * HOLD);
        for (int i = WORD_W - 1; i >= 0; i--)
        begin
            rd[i] = rb_dout;
            sclk_pin = (i > 0);
            hold(HOLD);
            sclk_pin = 1'b0;
            hold(2 * HOLD);
        end
        le_pin = 1'b0;
        hold(HOLD);
    endtask : read_reg

endmodule : pdc_host_model

// ===== bench/testbench.sv
// Self-checking bench for the register, calibration and divider-chain block.
// Assumes pdc_pkg, the design modules and the host model are compiled before it.
`timescale 1ns/10ps
module testbench;
    import pdc_pkg::*;

    // Ceiling on clock cycles; the tests need roughly fifty thousand.
    localparam int LIMIT = 90000;
    logic clk;
    logic srst;
    logic src = 1'b0;
    logic sclk_pin;
    logic data_pin;
    logic le_pin;
    logic rb_dout;
    logic sync_pulse;
    logic cal_busy;
    pdc_cfg_t cfg;
    pdc_ticks_t ticks;
    logic [WORD_W-1:0] rd;
    logic [4:0] resv [5] = '{5'h09, 5'h10, 5'h11, 5'h16, 5'h17};
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int e_cnt = 0;
    int busy_len = 0;
    int sync_cnt = 0;
    int pc [4] = '{0, 0, 0, 0};

    pdc_top dut_u (.clk(clk), .srst(srst), .sclk_pin(sclk_pin), .data_pin(data_pin), .le_pin(le_pin),
        .ref_pin(src), .osc_pin(src), .core_osc_pin(src), .cfg(cfg), .rb_dout(rb_dout),
        .ticks(ticks), .sync_pulse(sync_pulse), .cal_busy(cal_busy));
    pdc_host_model host_u (.clk(clk), .rb_dout(rb_dout), .sclk_pin(sclk_pin), .data_pin(data_pin),
        .le_pin(le_pin));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and one source wave shared by all three frequency inputs.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always
    begin
        repeat (4) @(negedge clk);
        src = ~src;
        e_cnt += src;
    end

    // Counters of busy cycles, sync pulses and divided ticks; also the hang limit.
    always @(posedge clk)
    begin
        cyc++;
        busy_len += cal_busy;
        sync_cnt += sync_pulse;
        for (int k = 0; k < 4; k++)
            pc[k] += ticks[k];
        if (cyc == LIMIT)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic check(input bit ok, input string what);
        compares++;
        if (!ok)
        begin
            n_fail++;
            $display("BAD t=%0t %s", $time, what);
        end
    endtask : check

    task automatic done(input string what);
        $display("test %s finished", what);
    endtask : done

    task automatic tally_and_finish();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // Divided ticks against source edges; one pulse of slack covers divider phase.
    task automatic meas(input int k, input int ratio, input int mult);
        int ex;
        e_cnt = 0;
        pc[k] = 0;
        repeat (800) @(negedge clk);
        ex = e_cnt * mult / ratio;
        check(pc[k] >= ex - 1 && pc[k] <= ex + 1, "tick rate");
    endtask : meas

    task automatic wait_idle();
        for (int i = 0; i < 3000 && cal_busy !== 1'b0; i++)
            @(negedge clk);
    endtask : wait_idle

    function automatic logic [31:0] w30(input int p, input int n);
        return {5'h00, p[2:0], 1'b0, n[17:0], ADDR_FB};
    endfunction : w30

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cfg = '0;
        cfg.mode = MODE_DUAL;
        cfg.post_sel = 1'b0;
        srst = 1'b1;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        check(cal_busy === 1'b0 && sync_pulse === 1'b0 && ticks === 4'h0, "reset outputs");
        host_u.read_reg(ADDR_FB, 1'b0, 1'b0, rd);
        check(rd === 32'h0000_0000, "feedback reset value");
        done("reset");
        // Calibration divider differs from the normal one so that the swap shows.
        host_u.write_word({9'h000, 18'h00004, ADDR_CAL});
        busy_len = 0;
        sync_cnt = 0;
        host_u.write_word(w30(3, 2));
        repeat (50) @(negedge clk);
        meas(0, 12, 1);
        wait_idle();
        check(busy_len === CAL_CYCLES, "calibration length");
        check(sync_cnt === 1, "sync pulse");
        meas(0, 6, 1);
        for (int c = 0; c < 8; c++)
        begin
            host_u.write_word(w30(c, 1));
            wait_idle();
            meas(0, (c == 0) ? 8 : (c < 3) ? 2 : c, 1);
        end
        done("calibration");
        host_u.write_word({10'h000, 2'h1, 14'h0003, 1'b0, ADDR_LOOP1_REF});
        meas(3, 6, 1);
        host_u.write_word({12'h004, 14'h0006, 1'b0, ADDR_DIVS});
        meas(1, 4, 1);
        meas(2, 6, 1);
        cfg.osc_src_div = 1'b1;
        cfg.osc_div_ratio = 8'h02;
        meas(2, 12, 1);
        host_u.write_word({2'h0, 1'b1, 24'h000000, ADDR_DBL});
        meas(1, 4, 2);
        cfg.mode = MODE_DUAL_ZD;
        cfg.chan_a_ratio = 11'h002;
        cfg.chan_b_ratio = 11'h002;
        meas(2, 12, 1);
        cfg.mode = MODE_SINGLE_ZD;
        meas(0, 2, 1);
        cfg.mode = MODE_EXT;
        cfg.post_ratio = 3'h2;
        meas(0, 14, 1);
        busy_len = 0;
        host_u.write_word(w30(7, 1));
        check(busy_len === 0, "external mode calibration");
        cfg.mode = MODE_DUAL;
        done("dividers");
        host_u.read_reg(ADDR_FB, 1'b1, 1'b0, rd);
        check((rd & 32'hFFFF_FFE0) === (w30(7, 1) & 32'hFFFF_FFE0), "readback high latch");
        host_u.read_reg(ADDR_STATUS_RB, 1'b0, 1'b0, rd);
        check(rd[20:16] === 5'h0C, "select field echo");
        foreach (resv[i])
        begin
            host_u.write_word({27'h5A5A5A5, resv[i]});
            host_u.read_reg(resv[i], 1'b0, 1'b0, rd);
            check(rd === 32'h0000_0000, "reserved readback");
        end
        done("readback");
        host_u.read_reg(ADDR_CAL, 1'b0, 1'b1, rd);
        check(rd[22:5] === 18'h00004, "read while locked");
        busy_len = 0;
        host_u.write_word({9'h000, 18'h00009, ADDR_CAL});
        host_u.write_word(w30(4, 5));
        repeat (20) @(negedge clk);
        check(busy_len === 0, "locked feedback write");
        host_u.read_reg(ADDR_PROT, 1'b0, 1'b1, rd);
        check(rd[5] === 1'b1, "lock bit");
        host_u.read_reg(ADDR_CAL, 1'b0, 1'b1, rd);
        check(rd[22:5] === 18'h00004, "locked write refused");
        host_u.read_reg(ADDR_CAL, 1'b0, 1'b0, rd);
        host_u.write_word({9'h000, 18'h00009, ADDR_CAL});
        host_u.read_reg(ADDR_CAL, 1'b0, 1'b0, rd);
        check(rd[22:5] === 18'h00009, "write after unlock");
        done("protect");
        tally_and_finish();
    end

endmodule : testbench
